// [verilog/debug_step_branch_trace.sv]
module debug_step_branch_trace
	import dbg_trace_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Retirement
	input wire logic retire_valid,
	input wire retire_class_t retire_class,
	input wire logic [7:0] retire_int_vector,
	input wire logic retire_sets_tf,
	input wire logic [ADDR_W-1:0] retire_offset,
	input wire logic [ADDR_W-1:0] next_offset,
	// Asynchronous event entry
	input wire async_event_t event_kind,
	input wire logic [ADDR_W-1:0] event_from_offset,
	input wire logic [ADDR_W-1:0] handler_offset,
	input wire logic ext_int_pending,
	// Software writes
	input wire logic tf_write,
	input wire logic tf_write_value,
	input wire logic ctl_write,
	input wire logic ctl_record_value,
	input wire logic ctl_step_value,
	input wire logic cause_clear,
	// Flags and state
	output logic trap_flag,
	output logic saved_trap_flag,
	output logic branch_record_enable,
	output logic branch_step_enable,
	output logic single_step_cause_bit,
	// Exception requests to the sequencer
	output logic debug_exception,
	output logic breakpoint_exception,
	output logic [7:0] exc_vector,
	output logic take_pending_int,
	// Records
	output logic [ADDR_W-1:0] branch_source_record,
	output logic [ADDR_W-1:0] branch_target_record,
	output logic [ADDR_W-1:0] exception_source_record,
	output logic [ADDR_W-1:0] exception_target_record
);

	////////////////////////////////////////////////////////////////////
	// Classification

	function automatic logic is_soft_int(input retire_class_t c);
		return c == RET_SOFT_INT || c == RET_ONE_BYTE_BP || c == RET_OVERFLOW_TRAP;
	endfunction

	function automatic logic is_xfer(input retire_class_t c);
		return c != RET_PLAIN;
	endfunction

	logic ret_xfer;
	logic ev_xfer;
	logic any_xfer;
	logic bp_instr;
	logic soft_int;
	logic step_due;
	logic step_arm;
	logic [1:0] quiet;

	assign ret_xfer = retire_valid && is_xfer(retire_class);
	assign ev_xfer = event_kind != EV_NONE;
	assign any_xfer = ret_xfer || ev_xfer;
	assign soft_int = retire_valid && is_soft_int(retire_class);
	assign bp_instr = retire_valid && (retire_class == RET_ONE_BYTE_BP ||
		(retire_class == RET_SOFT_INT && retire_int_vector == VEC_BREAKPOINT));

	////////////////////////////////////////////////////////////////////
	// Single-step decision

	// Quiet window covers the setter and the one instruction after it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			quiet <= 2'h0;
		end else if (retire_valid && retire_sets_tf && !trap_flag) begin
			quiet <= QUIET_INIT;
		end else if (retire_valid && quiet != 2'h0) begin
			quiet <= quiet - 2'h1;
		end
	end

	assign step_arm = trap_flag && quiet == 2'h0 && !(retire_sets_tf && !trap_flag);
	always_comb begin
		if (!step_arm || soft_int) begin
			step_due = 1'b0;
		end else if (branch_step_enable) begin
			step_due = any_xfer;
		end else begin
			step_due = retire_valid;
		end
	end

	assign debug_exception = step_due || (retire_valid && retire_class == RET_DEBUG_TRAP);
	assign breakpoint_exception = bp_instr && !step_due;
	always_comb begin
		if (debug_exception) begin
			exc_vector = VEC_DEBUG;
		end else if (breakpoint_exception) begin
			exc_vector = VEC_BREAKPOINT;
		end else begin
			exc_vector = 8'h00;
		end
	end
	// Step trap wins; the pending interrupt is taken at handler entry
	assign take_pending_int = step_due && ext_int_pending;

	////////////////////////////////////////////////////////////////////
	// Trap flag and saved image

	always_ff @(posedge clk) begin
		if (!nrst) begin
			trap_flag <= 1'b0;
		end else if (debug_exception) begin
			trap_flag <= 1'b0;
		end else if (soft_int) begin
			trap_flag <= 1'b0;
		end else if (retire_valid && retire_class == RET_INT_RETURN) begin
			trap_flag <= saved_trap_flag;
		end else if (tf_write) begin
			trap_flag <= tf_write_value;
		end else if (retire_valid && retire_sets_tf) begin
			trap_flag <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			saved_trap_flag <= 1'b0;
		end else if (debug_exception || soft_int || ev_xfer) begin
			saved_trap_flag <= trap_flag;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control and status bits

	always_ff @(posedge clk) begin
		if (!nrst) begin
			branch_record_enable <= 1'b0;
			branch_step_enable <= 1'b0;
		end else if (debug_exception) begin
			branch_record_enable <= 1'b0;
			branch_step_enable <= 1'b0;
		end else if (ctl_write) begin
			branch_record_enable <= ctl_record_value;
			branch_step_enable <= ctl_step_value;
		end
	end

	// Hardware set beats a simultaneous software clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			single_step_cause_bit <= 1'b0;
		end else if (step_due) begin
			single_step_cause_bit <= 1'b1;
		end else if (cause_clear) begin
			single_step_cause_bit <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transfer records

	logic upd_branch;
	logic upd_exception;
	logic [ADDR_W-1:0] src_sel;
	logic [ADDR_W-1:0] dst_sel;
	logic exc_copy;

	// Offsets only; code-segment base is never added
	assign src_sel = ev_xfer ? event_from_offset : retire_offset;
	assign dst_sel = ev_xfer ? handler_offset : next_offset;
	assign upd_branch = branch_record_enable && any_xfer && !debug_exception;
	assign exc_copy = (ev_xfer && event_kind != EV_MACHINE_CHECK) ||
		(soft_int && !bp_instr) || bp_instr;
	assign upd_exception = upd_branch && exc_copy;

	transfer_records u_records (
		.clk(clk),
		.nrst(nrst),
		.upd_branch(upd_branch),
		.upd_exception(upd_exception),
		.src_offset(src_sel),
		.dst_offset(dst_sel),
		.branch_source_record(branch_source_record),
		.branch_target_record(branch_target_record),
		.exception_source_record(exception_source_record),
		.exception_target_record(exception_target_record)
	);

	////////////////////////////////////////////////////////////////////
	// Checks

	chk_step_clears_tf: assert property (
		@(posedge clk) disable iff (!nrst)
		step_due |=> !trap_flag && single_step_cause_bit)
		else $error("trap flag not cleared or cause not set after step");

	chk_step_every_instr: assert property (
		@(posedge clk) disable iff (!nrst)
		retire_valid && step_arm && !branch_step_enable && !soft_int |-> debug_exception)
		else $error("missing single-step exception");

	chk_no_step_setter: assert property (
		@(posedge clk) disable iff (!nrst)
		retire_valid && retire_sets_tf && !trap_flag |-> !step_due)
		else $error("step raised on the setter");

	chk_no_step_follower: assert property (
		@(posedge clk) disable iff (!nrst)
		retire_valid && quiet != 2'h0 |-> !step_due)
		else $error("step raised on the follower");

	chk_quiet_armed: assert property (
		@(posedge clk) disable iff (!nrst)
		retire_valid && retire_sets_tf && !trap_flag |=> quiet == QUIET_INIT)
		else $error("quiet window not opened by setter");

	chk_cause_bit_set: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(single_step_cause_bit) |-> $past(step_due))
		else $error("cause bit rose without a step");

	chk_cause_set_wins: assert property (
		@(posedge clk) disable iff (!nrst)
		step_due && cause_clear |=> single_step_cause_bit)
		else $error("clear beat a simultaneous step");

	chk_cause_clear: assert property (
		@(posedge clk) disable iff (!nrst)
		cause_clear && !step_due |=> !single_step_cause_bit)
		else $error("cause bit not cleared");

	chk_saved_image: assert property (
		@(posedge clk) disable iff (!nrst)
		step_due |=> saved_trap_flag)
		else $error("saved image lost the trap flag");

	chk_interrupt_return_instr_restore: assert property (
		@(posedge clk) disable iff (!nrst)
		retire_valid && retire_class == RET_INT_RETURN && !debug_exception
		|=> trap_flag == $past(saved_trap_flag))
		else $error("interrupt return did not restore trap flag");

	chk_int_after_step: assert property (
		@(posedge clk) disable iff (!nrst)
		ext_int_pending && step_due |-> take_pending_int && exc_vector == VEC_DEBUG)
		else $error("pending interrupt not deferred behind step trap");

	chk_no_grant_idle: assert property (
		@(posedge clk) disable iff (!nrst)
		!step_due |-> !take_pending_int)
		else $error("pending interrupt granted without a step trap");

	chk_softint_clears: assert property (
		@(posedge clk) disable iff (!nrst)
		soft_int |=> !trap_flag)
		else $error("software interrupt left trap flag set");

	chk_softint_no_step: assert property (
		@(posedge clk) disable iff (!nrst)
		soft_int |-> !step_due)
		else $error("software interrupt was stepped");

	chk_bp_vector: assert property (
		@(posedge clk) disable iff (!nrst)
		bp_instr && !step_due |-> breakpoint_exception && exc_vector == VEC_BREAKPOINT)
		else $error("breakpoint not routed to vector 3");

	chk_bp_not_debug: assert property (
		@(posedge clk) disable iff (!nrst)
		breakpoint_exception |-> exc_vector != VEC_DEBUG)
		else $error("breakpoint sent to the debug vector");

	chk_plain_no_xfer: assert property (
		@(posedge clk) disable iff (!nrst)
		retire_class == RET_PLAIN && event_kind == EV_NONE |-> !any_xfer)
		else $error("plain instruction counted as transfer");

	chk_event_is_xfer: assert property (
		@(posedge clk) disable iff (!nrst)
		event_kind != EV_NONE |-> any_xfer)
		else $error("event not counted as transfer");

	chk_record_update: assert property (
		@(posedge clk) disable iff (!nrst)
		branch_record_enable && any_xfer && !debug_exception
		|=> branch_source_record == $past(src_sel) && branch_target_record == $past(dst_sel))
		else $error("branch records not updated on transfer");

	chk_branch_offsets: assert property (
		@(posedge clk) disable iff (!nrst)
		upd_branch && !ev_xfer |=> branch_target_record == $past(next_offset))
		else $error("branch target is not the next offset");

	chk_event_offsets: assert property (
		@(posedge clk) disable iff (!nrst)
		upd_branch && ev_xfer |=> branch_source_record == $past(event_from_offset)
		&& branch_target_record == $past(handler_offset))
		else $error("event records not interrupted and handler offsets");

	chk_exc_copy: assert property (
		@(posedge clk) disable iff (!nrst)
		upd_exception |=> exception_source_record == branch_source_record
		&& exception_target_record == branch_target_record)
		else $error("exception records not copied from branch records");

	chk_no_copy_mc: assert property (
		@(posedge clk) disable iff (!nrst)
		event_kind == EV_MACHINE_CHECK && !soft_int |=> $stable(exception_source_record)
		&& $stable(exception_target_record))
		else $error("machine check changed exception records");

	chk_debug_clears_rec: assert property (
		@(posedge clk) disable iff (!nrst)
		debug_exception |=> !branch_record_enable)
		else $error("debug exception left recording on");

	chk_records_kept: assert property (
		@(posedge clk) disable iff (!nrst)
		debug_exception |=> $stable(branch_source_record) && $stable(branch_target_record)
		&& $stable(exception_source_record) && $stable(exception_target_record))
		else $error("records changed on debug exception");

	chk_no_base: assert property (
		@(posedge clk) disable iff (!nrst)
		upd_branch && !ev_xfer |=> branch_source_record == $past(retire_offset))
		else $error("branch source is not the plain offset");

	chk_branch_only: assert property (
		@(posedge clk) disable iff (!nrst)
		branch_step_enable && retire_valid && !any_xfer |-> !step_due)
		else $error("step trap on plain instruction in branch-step mode");

	chk_branch_step: assert property (
		@(posedge clk) disable iff (!nrst)
		step_arm && branch_step_enable && any_xfer && !soft_int |-> debug_exception)
		else $error("no step trap on transfer in branch-step mode");

	chk_debug_clears_ctl: assert property (
		@(posedge clk) disable iff (!nrst)
		debug_exception |=> !branch_step_enable && !trap_flag)
		else $error("debug exception left step bits set");

	chk_reset_clears: assert property (
		@(posedge clk)
		!nrst |=> !branch_record_enable && !branch_step_enable
		&& branch_source_record == RECORD_RESET && exception_target_record == RECORD_RESET)
		else $error("reset did not clear enables and records");

	chk_hold_disabled: assert property (
		@(posedge clk) disable iff (!nrst)
		!branch_record_enable |=> $stable(branch_source_record)
		&& $stable(branch_target_record) && $stable(exception_source_record))
		else $error("records changed while recording is off");

	chk_ctl_write: assert property (
		@(posedge clk) disable iff (!nrst)
		ctl_write && !debug_exception |=> branch_record_enable == $past(ctl_record_value)
		&& branch_step_enable == $past(ctl_step_value))
		else $error("control write did not take effect");

endmodule // debug_step_branch_trace

// [verilog/dbg_trace_pkg.sv]
package dbg_trace_pkg;

	localparam int ADDR_W = 64;
	localparam logic [7:0] VEC_DEBUG = 8'h01;
	localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
	localparam logic [7:0] VEC_MACHINE_CHECK = 8'h12;
	localparam logic [ADDR_W-1:0] RECORD_RESET = 64'h0000000000000000;
	// Retirements left unstepped after the one that sets the trap flag
	localparam logic [1:0] QUIET_INIT = 2'h1;

	// Retirement classes reported by the core
	typedef enum logic [3:0] {
		RET_PLAIN = 4'h0,
		RET_NEAR_BRANCH = 4'h1,
		RET_FAR_BRANCH = 4'h2,
		RET_COND_BRANCH = 4'h3,
		RET_SOFT_INT = 4'h4,
		RET_ONE_BYTE_BP = 4'h5,
		RET_OVERFLOW_TRAP = 4'h6,
		RET_DEBUG_TRAP = 4'h7,
		RET_INT_RETURN = 4'h8,
		RET_SYS_CALL = 4'h9,
		RET_RESUME_SMM = 4'hA
	} retire_class_t;

	// Asynchronous events delivered by the core sequencer
	typedef enum logic [2:0] {
		EV_NONE = 3'h0,
		EV_EXCEPTION = 3'h1,
		EV_EXT_INT = 3'h2,
		EV_NMI = 3'h3,
		EV_SMI = 3'h4,
		EV_MACHINE_CHECK = 3'h5
	} async_event_t;

endpackage

// [verilog/transfer_records.sv]
// Four transfer records; branch pair and exception pair written on separate update strobes
module transfer_records
	import dbg_trace_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Update controls
	input wire logic upd_branch,
	input wire logic upd_exception,
	input wire logic [ADDR_W-1:0] src_offset,
	input wire logic [ADDR_W-1:0] dst_offset,
	// Record contents
	output logic [ADDR_W-1:0] branch_source_record,
	output logic [ADDR_W-1:0] branch_target_record,
	output logic [ADDR_W-1:0] exception_source_record,
	output logic [ADDR_W-1:0] exception_target_record
);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			branch_source_record <= RECORD_RESET;
			branch_target_record <= RECORD_RESET;
		end else if (upd_branch) begin
			branch_source_record <= src_offset;
			branch_target_record <= dst_offset;
		end
	end

	// Exception copy takes the branch pair as it stands after this transfer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			exception_source_record <= RECORD_RESET;
			exception_target_record <= RECORD_RESET;
		end else if (upd_exception) begin
			exception_source_record <= src_offset;
			exception_target_record <= dst_offset;
		end
	end

endmodule // transfer_records

// [sim/core_int_source.sv]
// Stand-in for the external interrupt source on the sequencer side
module core_int_source (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Request from the bench, grant from the block
	input wire logic raise_int,
	input wire logic take_pending_int,
	// Level toward the block
	output logic ext_int_pending
);
	timeunit 1ns;
	timeprecision 1ps;

	// Held until granted, so a late grant is never missed
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ext_int_pending <= 1'b0;
		end else if (raise_int) begin
			ext_int_pending <= 1'b1;
		end else if (take_pending_int) begin
			ext_int_pending <= 1'b0;
		end
	end
endmodule // core_int_source

// [sim/tb_top.sv]
module tb_top
	import dbg_trace_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic retire_valid = 1'b0;
	retire_class_t retire_class = RET_PLAIN;
	logic [7:0] retire_int_vector = 8'h00;
	logic retire_sets_tf = 1'b0;
	logic [ADDR_W-1:0] retire_offset = '0, next_offset = '0;
	async_event_t event_kind = EV_NONE;
	logic [ADDR_W-1:0] event_from_offset = '0, handler_offset = '0;
	logic ext_int_pending, take_pending_int;
	logic raise_int = 1'b0, tf_write = 1'b0, tf_write_value = 1'b0, cause_clear = 1'b0;
	logic ctl_write = 1'b0, ctl_record_value = 1'b0, ctl_step_value = 1'b0;
	logic trap_flag, saved_trap_flag, branch_record_enable, branch_step_enable;
	logic single_step_cause_bit, debug_exception, breakpoint_exception;
	logic [7:0] exc_vector;
	logic [ADDR_W-1:0] bsrc, btgt, esrc, etgt;
	int n_errors = 0;
	int compares = 0;

	typedef struct packed {
		retire_class_t c; logic [7:0] v; logic tf; logic dbg; logic bp; logic [7:0] vec;
	} row_t;
	row_t rows[11] = '{
		'{RET_PLAIN, 8'h00, '0, '0, '0, 8'h00}, '{RET_PLAIN, 8'h00, '1, '1, '0, 8'h01},
		'{RET_NEAR_BRANCH, 8'h00, '1, '1, '0, 8'h01}, '{RET_SYS_CALL, 8'h00, '1, '1, '0, 8'h01},
		'{RET_ONE_BYTE_BP, 8'h00, '0, '0, '1, 8'h03}, '{RET_SOFT_INT, 8'h03, '0, '0, '1, 8'h03},
		'{RET_SOFT_INT, 8'h21, '0, '0, '0, 8'h00}, '{RET_SOFT_INT, 8'h21, '1, '0, '0, 8'h00},
		'{RET_OVERFLOW_TRAP, 8'h00, '1, '0, '0, 8'h00}, '{RET_ONE_BYTE_BP, 8'h00, '1, '0, '1, 8'h03},
		'{RET_DEBUG_TRAP, 8'h00, '0, '1, '0, 8'h01}};

	always #12.5 clk = ~clk;

	debug_step_branch_trace dut (.clk, .nrst, .retire_valid, .retire_class, .retire_int_vector,
		.retire_sets_tf, .retire_offset, .next_offset, .event_kind, .event_from_offset,
		.handler_offset, .ext_int_pending, .tf_write, .tf_write_value, .ctl_write,
		.ctl_record_value, .ctl_step_value, .cause_clear, .trap_flag, .saved_trap_flag,
		.branch_record_enable, .branch_step_enable, .single_step_cause_bit, .debug_exception,
		.breakpoint_exception, .exc_vector, .take_pending_int, .branch_source_record(bsrc),
		.branch_target_record(btgt), .exception_source_record(esrc),
		.exception_target_record(etgt));

	core_int_source partner (.clk, .nrst, .raise_int, .take_pending_int, .ext_int_pending);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Source offsets (retire_offset, event_from_offset) are inverted while idle so stale values cannot pass as fresh ones
	task automatic idle;
		@(posedge clk);
		{retire_valid, retire_sets_tf, ctl_write, tf_write, cause_clear, raise_int} <= '0;
		event_kind <= EV_NONE;
		retire_offset <= ~retire_offset;
		event_from_offset <= ~event_from_offset;
		#1;
	endtask

	task automatic retire(input retire_class_t c, input logic [7:0] v, input logic s,
		input logic [63:0] f, input logic [63:0] t);
		@(posedge clk);
		{retire_valid, retire_class, retire_int_vector, retire_sets_tf} <= {1'b1, c, v, s};
		{retire_offset, next_offset} <= {f, t};
		#1;
	endtask

	task automatic ev(input async_event_t k, input logic [63:0] f, input logic [63:0] t);
		@(posedge clk);
		{event_kind, event_from_offset, handler_offset} <= {k, f, t};
		idle();
	endtask

	task automatic ctl(input logic r, input logic s);
		@(posedge clk);
		{ctl_write, ctl_record_value, ctl_step_value} <= {1'b1, r, s};
		idle();
	endtask

	// Setter plus its follower; neither may step
	task automatic arm_tf;
		retire(RET_PLAIN, 8'h00, 1'b1, 64'h10, 64'h14);
		check("setter_step", debug_exception, 1'b0);
		idle();
		retire(RET_PLAIN, 8'h00, 1'b0, 64'h14, 64'h18);
		check("follower_step", debug_exception, 1'b0);
		idle();
	endtask

	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check("reset_flags", {trap_flag, branch_record_enable, branch_step_enable}, 0);
		check("reset_records", bsrc | btgt | esrc | etgt, 64'h0);
		foreach (rows[i]) begin
			if (rows[i].tf) arm_tf();
			retire(rows[i].c, rows[i].v, 1'b0, 64'h20, 64'h30);
			check("debug_exc", debug_exception, rows[i].dbg);
			check("bp_exc", breakpoint_exception, rows[i].bp);
			check("exc_vector", exc_vector, rows[i].vec);
			idle();
			check("trap_flag_after", trap_flag, 1'b0);
		end
		// Recording: branch, interrupt, machine check, then disabled
		ctl(1'b1, 1'b0);
		retire(RET_NEAR_BRANCH, 8'h00, 1'b0, 64'hFFFF000000001000, 64'h2000);
		idle();
		check("br_src", bsrc, 64'hFFFF000000001000);
		check("br_tgt", btgt, 64'h2000);
		check("ex_src_branch", esrc, 64'h0);
		ev(EV_EXT_INT, 64'h3000, 64'h4000);
		check("br_src_int", bsrc, 64'h3000);
		check("ex_tgt_int", etgt, 64'h4000);
		ev(EV_MACHINE_CHECK, 64'h5000, 64'h6000);
		check("br_tgt_mc", btgt, 64'h6000);
		check("ex_src_mc", esrc, 64'h3000);
		ctl(1'b0, 1'b0);
		retire(RET_FAR_BRANCH, 8'h00, 1'b0, 64'h7000, 64'h8000);
		idle();
		check("rec_hold", bsrc, 64'h5000);
		// Branch-step mode with recording on
		ctl(1'b1, 1'b1);
		arm_tf();
		retire(RET_PLAIN, 8'h00, 1'b0, 64'h18, 64'h1C);
		check("btf_plain", debug_exception, 1'b0);
		idle();
		retire(RET_COND_BRANCH, 8'h00, 1'b0, 64'h9000, 64'hA000);
		check("btf_branch", debug_exception, 1'b1);
		idle();
		check("rec_kept", btgt, 64'h6000);
		check("rec_en_off", branch_record_enable, 1'b0);
		check("step_en_off", {branch_step_enable, trap_flag}, 2'b00);
		check("cause_set", single_step_cause_bit, 1'b1);
		check("saved_tf", saved_trap_flag, 1'b1);
		retire(RET_INT_RETURN, 8'h00, 1'b0, 64'hB000, 64'h9004);
		idle();
		check("interrupt_return_instr_tf", trap_flag, 1'b1);
		@(posedge clk);
		{cause_clear, tf_write} <= 2'b11;
		idle();
		check("cause_clr", {single_step_cause_bit, trap_flag}, 2'b00);
		// Step trap against a pending external interrupt
		@(posedge clk);
		raise_int <= 1'b1;
		idle();
		arm_tf();
		retire(RET_PLAIN, 8'h00, 1'b0, 64'h18, 64'h1C);
		check("step_first", debug_exception, 1'b1);
		check("int_after", take_pending_int, 1'b1);
		idle();
		check("tf_cleared", trap_flag, 1'b0);
		// Mid-run reset with records and cause bit holding values
		@(posedge clk);
		nrst <= 1'b0;
		idle();
		@(posedge clk);
		nrst <= 1'b1;
		#1;
		check("rst_mid_rec", bsrc | btgt | esrc | etgt, 64'h0);
		check("rst_mid_ctl", {branch_record_enable, branch_step_enable}, 2'b00);
		end_sim();
	end
endmodule // tb_top
